// >>> verilog/osc_defines.svh
// Constants shared by the oscillator output stage.
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH
// Width of the divider select code and of the half-period counter.
`define OSC_CODE_W 4
`define OSC_HALF_W 8
// Position of the float-when-off bit inside the select code.
`define OSC_FLOAT_POS 3
// Clock edges in one master oscillator period (clk runs at twice master).
`define OSC_CLK_PER_MASTER 2
// Start-up interval in master periods, and its count in clk cycles.
`define OSC_STARTUP_MASTER 500
`define OSC_STARTUP_CYCLES (`OSC_STARTUP_MASTER * `OSC_CLK_PER_MASTER)
// Code filter settling time in master periods, and its count in clk cycles.
`define OSC_SETTLE_MASTER 96
`define OSC_SETTLE_CYCLES (`OSC_SETTLE_MASTER * `OSC_CLK_PER_MASTER)
// Half-period below which the first low time is half an output period.
`define OSC_FIRST_LOW_LIMIT 8'h04
// First low time for larger ratios: one master period in clk cycles.
`define OSC_FIRST_LOW_CYCLES 8'h02
// Reset values.
`define OSC_CODE_RESET 4'h0
`define OSC_HALF_RESET 8'h01
`endif

// >>> verilog/osc_pkg.sv
// Types shared by the oscillator output stage.
package osc_pkg;
  typedef logic [3:0] divider_select_code_t;
  typedef logic [7:0] halfCount_t;
  typedef enum logic [3:0]
  {
    ST_START = 4'b0001,
    ST_OFF = 4'b0010,
    ST_ALIGN = 4'b0100,
    ST_RUN = 4'b1000
  } outState_t;
endpackage

// >>> verilog/code_settle.sv
// Ratio quantiser, stability filter and select-code decoder.
`timescale 1ns/1ns
`include "osc_defines.svh"
module code_settle #(
  parameter int unsigned SETTLE = `OSC_SETTLE_CYCLES
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] ratioLevel,
  output osc_pkg::divider_select_code_t settledCode,
  output logic floatBit,
  output osc_pkg::halfCount_t halfCount,
  output logic codeValid
);
  import osc_pkg::*;

  // Half-period in clk cycles equals the division ratio.
  function automatic halfCount_t ratioOf(input divider_select_code_t c);
    logic [2:0] e;
    e = c[3] ? ~c[2:0] : c[2:0];
    return halfCount_t'(8'h01 << e);
  endfunction

  divider_select_code_t bandS1, bandS2, bandS3, candidate;
  logic [9:0] stableCnt;

  // Top nibble of the ratio gives sixteen equal bands; three stages sync it.
  always_ff @(posedge clk)
  begin
    bandS1 <= ratioLevel[7:4];
    bandS2 <= bandS1;
    bandS3 <= bandS2;
  end

  // A code is adopted only after it held still for the whole settle time,
  // so the output never wanders through neighbouring codes.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      candidate <= `OSC_CODE_RESET;
      stableCnt <= 10'h000;
      settledCode <= `OSC_CODE_RESET;
      floatBit <= 1'b0;
      halfCount <= `OSC_HALF_RESET;
      codeValid <= 1'b0;
    end
    else if (bandS2 != bandS3)
      stableCnt <= 10'h000;
    else if (candidate != bandS3)
    begin
      candidate <= bandS3;
      stableCnt <= 10'h000;
    end
    else if (stableCnt != 10'(SETTLE))
      stableCnt <= stableCnt + 10'h001;
    else
    begin
      settledCode <= candidate;
      floatBit <= candidate[`OSC_FLOAT_POS];
      halfCount <= ratioOf(candidate);
      codeValid <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_DECODE: assert property (codeValid |-> floatBit == settledCode[3] &&
    halfCount == (8'h01 << (settledCode[3] ? 4'd15 - settledCode : settledCode)))
    else $error("select code decoded to wrong ratio or float bit");

  AST_NO_WANDER: assert property ($changed(settledCode) |->
    $past(bandS3) == settledCode && $past(stableCnt) == 10'(SETTLE))
    else $error("select code changed before it was stable");
endmodule // code_settle

// >>> verilog/half_divider.sv
// Power-of-two divider toggling a square wave at each terminal count.
`timescale 1ns/1ns
`include "osc_defines.svh"
module half_divider (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restart,
  input osc_pkg::halfCount_t firstLow,
  input osc_pkg::halfCount_t halfCount,
  output logic divOut
);
  import osc_pkg::*;

  halfCount_t cnt;

  // New ratios are loaded only at a toggle, so every half-period is whole
  // and a ratio change never produces a sliver.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt <= 8'h00;
      divOut <= 1'b0;
    end
    else if (restart)
    begin
      divOut <= 1'b0;
      cnt <= firstLow - 8'h01;
    end
    else if (cnt == 8'h00)
    begin
      divOut <= ~divOut;
      cnt <= halfCount - 8'h01;
    end
    else
      cnt <= cnt - 8'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence termCount;
    cnt == 8'h00 && !restart;
  endsequence

  AST_TOGGLE: assert property (termCount |=> $changed(divOut))
    else $error("divider missed a toggle at terminal count");

  AST_RELOAD: assert property (termCount |=> cnt == $past(halfCount) - 8'h01)
    else $error("divider reloaded a wrong half-period");
endmodule // half_divider

// >>> verilog/oscillator_divider_enable.sv
// Output stage: start-up, enable synchronisation and pin drive.
//
// Overview of operation
// - Ratio input converted to four-bit select code.
// - Code top bit is the float-when-off bit.
// - Disabled output low, or floating when bit set.
// - Gate high lets divided clock reach output.
// - Gate low disables output at once, unclocked.
// - Enabled output waits low to align, no slivers.
// - Divide master by 1 to 128 powers of two.
// - Codes 0-7: no float, ratio two to code.
// - Codes 8-15: float, ratio two to 15-code.
// - Start-up waits for stable valid select code.
// - Ratio quantised into sixteen equal bands.
// - Enable latency bounded by output or master periods.
// - Code changes adopted only when stable, glitch-free.
// - Output floats during the start-up interval.
// - First rise follows one master period low, half a master period at ratio 1.
`timescale 1ns/1ns
`include "osc_defines.svh"
module oscillator_divider_enable #(
  parameter int unsigned STARTUP = `OSC_STARTUP_CYCLES,
  parameter int unsigned SETTLE = `OSC_SETTLE_CYCLES
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] ratioLevel,
  input wire logic driveGate,
  output logic pinOut,
  output logic pinOutEn,
  output osc_pkg::divider_select_code_t divSelCode,
  output logic floatWhenOffBit,
  output logic startupDone
);
  import osc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  outState_t state;
  halfCount_t halfCount;
  halfCount_t firstLow;
  logic codeValid;
  logic divOut;
  logic gateS1, gateS2, gateS3;
  logic gateOn;
  logic gateRise;
  logic activeReg;
  logic outReg;
  logic holdLowReg;
  logic [10:0] startCnt;
  logic startEnd;

  // ----------------------------------------------------------------
  // Select code
  // ----------------------------------------------------------------

  // Quantise, filter and decode the ratio input.
  code_settle #(
    .SETTLE(SETTLE)
  ) codeUnit (
    .clk(clk),
    .reset_n(reset_n),
    .ratioLevel(ratioLevel),
    .settledCode(divSelCode),
    .floatBit(floatWhenOffBit),
    .halfCount(halfCount),
    .codeValid(codeValid)
  );

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------

  // Small ratios start with half an output period low, others with one
  // master period, so the first high pulse always has its full width.
  assign firstLow = (halfCount < `OSC_FIRST_LOW_LIMIT) ?
    halfCount : `OSC_FIRST_LOW_CYCLES;

  // The divider restarts in the align state so the output phase is known.
  half_divider divUnit (
    .clk(clk),
    .reset_n(reset_n),
    .restart(state == ST_ALIGN),
    .firstLow(firstLow),
    .halfCount(halfCount),
    .divOut(divOut)
  );

  // ----------------------------------------------------------------
  // Gate synchroniser
  // ----------------------------------------------------------------

  // The gate pin is asynchronous; three stages feed the state machine.
  always_ff @(posedge clk)
  begin
    gateS1 <= driveGate;
    gateS2 <= gateS1;
    gateS3 <= gateS2;
  end

  // A level change counts only once the last two stages agree.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      gateOn <= 1'b0;
    else if (gateS2 == gateS3)
      gateOn <= gateS3;
  end

  assign gateRise = !gateOn && gateS2 && gateS3;

  // ----------------------------------------------------------------
  // Start-up timer
  // ----------------------------------------------------------------

  // Counts the power-on interval; it stops at its end value.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      startCnt <= 11'h000;
    else if (startCnt != 11'(STARTUP))
      startCnt <= startCnt + 11'h001;
  end

  assign startEnd = (startCnt == 11'(STARTUP));

  // ----------------------------------------------------------------
  // Output state machine
  // ----------------------------------------------------------------

  // Start-up is held until the code is valid, however long that takes.
  // A short gate dip that the synchroniser misses still clears the
  // active flag, so the run state goes back through align.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state <= ST_START;
    else
    begin
      case (state)
        ST_START:
        begin
          if (startEnd && codeValid)
            state <= gateOn ? ST_ALIGN : ST_OFF;
        end
        ST_OFF:
        begin
          if (gateOn || gateRise)
            state <= ST_ALIGN;
        end
        ST_ALIGN:
        begin
          state <= ST_RUN;
        end
        ST_RUN:
        begin
          if (!gateOn)
            state <= ST_OFF;
          else if (!activeReg)
            state <= ST_ALIGN;
        end
        default:
        begin
          state <= ST_START;
        end
      endcase
    end
  end

  // Reports that start-up has ended: interval over and select code valid.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      startupDone <= 1'b0;
    else
      startupDone <= (state != ST_START);
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------

  // These two flops clear the instant the gate falls, with no clock edge,
  // so a high pulse in progress is truncated rather than finished.
  always_ff @(posedge clk or negedge driveGate)
  begin
    if (!driveGate)
    begin
      activeReg <= 1'b0;
      outReg <= 1'b0;
    end
    else if (!reset_n)
    begin
      activeReg <= 1'b0;
      outReg <= 1'b0;
    end
    else
    begin
      activeReg <= (state == ST_ALIGN) || (state == ST_RUN && activeReg);
      outReg <= (state == ST_RUN && activeReg) ? divOut : 1'b0;
    end
  end

  // Holds the pin low while disabled unless the float bit is set; during
  // start-up the pin floats whatever the gate and float bit say.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      holdLowReg <= 1'b0;
    else
      holdLowReg <= (state != ST_START) && !floatWhenOffBit;
  end

  // The enable is an OR of two flops: one must clear asynchronously and
  // the other must not, since its disabled value depends on the float bit.
  assign pinOutEn = activeReg || holdLowReg;
  assign pinOut = outReg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence offSteady(logic f);
    (state == ST_OFF && floatWhenOffBit == f && !activeReg)[*2];
  endsequence

  sequence enableStart;
    state == ST_OFF && gateOn;
  endsequence

  sequence alignThenRun;
    state == ST_ALIGN ##1 state == ST_RUN;
  endsequence

  AST_STARTUP_FLOAT: assert property (state == ST_START |-> !pinOutEn)
    else $error("pin driven during start-up");

  AST_STARTUP_WAIT: assert property (state == ST_START && !codeValid |=>
    state == ST_START)
    else $error("start-up left before the code was valid");

  AST_GATE_OFF: assert property (!driveGate |-> !pinOut && !activeReg)
    else $error("output high while the gate is low");

  AST_HOLD_LOW: assert property (offSteady(1'b0) |-> pinOutEn && !pinOut)
    else $error("disabled output not held low");

  AST_FLOAT_OFF: assert property (offSteady(1'b1) |-> !pinOutEn)
    else $error("disabled output not floating");

  AST_ENABLE_LATENCY: assert property (enableStart |=> alignThenRun)
    else $error("enable took longer than allowed");

  AST_FIRST_LOW: assert property (state == ST_ALIGN |=> !pinOut[*2])
    else $error("first pulse rose too early after enable");

  AST_FOLLOW_DIV: assert property ((state == ST_RUN && activeReg)[*2] |->
    pinOut == $past(divOut))
    else $error("enabled output does not follow the divider");

  AST_DONE_FLAG: assert property (state != ST_START |=> startupDone)
    else $error("start-up done flag missing after start-up ended");

  AST_RUN_DRIVEN: assert property (state == ST_RUN && activeReg |-> pinOutEn)
    else $error("enabled output is not driven");

  // ----------------------------------------------------------------
  // High-time watchdog
  // ----------------------------------------------------------------

  // Counts how long the pin has stood high, so a lost toggle shows up
  // even at ratio 128, far beyond what a repetition could express.
  // The bound is the largest ratio, because a new ratio only takes hold
  // at the next toggle and the half-period in flight may be the old one.
  logic [8:0] highRun;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      highRun <= 9'h000;
    else if (pinOut)
      highRun <= highRun + 9'h001;
    else
      highRun <= 9'h000;
  end

  AST_HIGH_BOUND: assert property (highRun <= 9'h080)
    else $error("output stayed high longer than the largest half-period");
endmodule // oscillator_divider_enable

// >>> sim/load_model.sv
// Load on the output pin that resolves driven and floating levels.
`timescale 1ns/1ns
module load_model (
  input wire logic clk,
  input wire logic pinOut,
  input wire logic pinOutEn,
  output logic pinLevel
);
  logic lastLevel = 1'b0;
  // Remember the last driven level so that a floating pin reads as the inverse of it.
  always_ff @(posedge clk)
  begin
    if (pinOutEn)
    begin
      lastLevel <= pinOut;
    end
  end
  // A released pin shows the inverse of its last level, as nothing holds it.
  assign pinLevel = pinOutEn ? pinOut : ~lastLevel;
endmodule // load_model

// >>> sim/tb.sv
// Self-checking bench for the oscillator output stage.
`timescale 1ns/1ns
module tb;
  import osc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] ratioLevel = 8'h28;
  logic driveGate = 1'b1;
  logic pinOut, pinOutEn, floatWhenOffBit, startupDone, pinLevel;
  divider_select_code_t divSelCode;
  int fail_count = 0;
  int comparisons = 0;
  int hi, lo, wt;
  oscillator_divider_enable #(.STARTUP(20), .SETTLE(8)) i_oscillator_divider_enable (
    .clk(clk),
    .reset_n(reset_n),
    .ratioLevel(ratioLevel),
    .driveGate(driveGate),
    .pinOut(pinOut),
    .pinOutEn(pinOutEn),
    .divSelCode(divSelCode),
    .floatWhenOffBit(floatWhenOffBit),
    .startupDone(startupDone)
  );
  load_model i_load_model (
    .clk(clk),
    .pinOut(pinOut),
    .pinOutEn(pinOutEn),
    .pinLevel(pinLevel)
  );
  // Clock at 10 MHz.
  always #50 clk = ~clk;
  // Compare and count.
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    comparisons++;
    if (seen !== expected)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, expected);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic close_out;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Count falling edges until the pin is driven to a level; a hang ends the run.
  task automatic wait_level(input logic level, output int n);
    n = 0;
    while (!(pinOutEn === 1'b1 && pinLevel === level))
    begin
      @(negedge clk);
      n++;
      if (n > 1000)
      begin
        fail_count++;
        close_out();
      end
    end
  endtask
  // Time to first rise, then one high and one low width in clk cycles.
  task automatic measure;
    wait_level(1'b1, wt);
    wait_level(1'b0, hi);
    wait_level(1'b1, lo);
  endtask
  // Wait for the settled code under a bound.
  task automatic wait_code(input divider_select_code_t c);
    for (int i = 0; divSelCode !== c; i++)
    begin
      @(negedge clk);
      if (i > 300)
      begin
        fail_count++;
        close_out();
      end
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    // A wandering ratio input must hold start-up well past its nominal length.
    for (int i = 0; i < 16; i++)
    begin
      ratioLevel = i[0] ? 8'h58 : 8'h28;
      repeat (4) @(negedge clk);
      check(startupDone, 1'b0);
      check(pinOutEn, 1'b0);
    end
    ratioLevel = 8'h28;
    wait_code(4'h2);
    for (int i = 0; startupDone !== 1'b1 && i < 50; i++)
      @(negedge clk);
    check(startupDone, 1'b1);
    check({pinOutEn, pinOut}, 2'b10);
    measure();
    check(hi, 16'h4);
    driveGate = 1'b0;
    // Every code: decode, disabled state, enable latency, widths, async disable.
    for (int c = 0; c < 16; c++)
    begin
      ratioLevel = {c[3:0], 4'h8};
      wait_code(c[3:0]);
      repeat (8) @(negedge clk);
      check(floatWhenOffBit, c[3]);
      check(pinOutEn, !c[3]);
      check(pinOut, 1'b0);
      driveGate = 1'b1;
      measure();
      check(wt <= 10, 1'b1);
      check(hi, 16'h1 << (c < 8 ? c : 15 - c));
      check(lo, 16'h1 << (c < 8 ? c : 15 - c));
      // The pin has just risen, so this drop truncates a high pulse.
      driveGate = 1'b0;
      #1;
      check(pinOut, 1'b0);
      check(pinOutEn, !c[3]);
    end
    close_out();
  end
endmodule // tb
